// [apc_consts.svh]
// Constants of the parallel output control block.
// Assumes inclusion by bare name from the package and the design.
`ifndef APC_CONSTS_SVH
`define APC_CONSTS_SVH
`define APC_DATA_W        16
`define APC_RATIO_NORM    3'h6
`define APC_RATIO_DOUBLE  3'h3
`define APC_STROBE_HALF   4
`define APC_SETTLE_CYCLES 55
`define APC_PIN_RST       5'h0f
`define APC_PIN_DBL       4
`define APC_PIN_PD_N      3
`define APC_PIN_SYNC_N    2
`define APC_PIN_CS_N      1
`define APC_PIN_RD_N      0
`endif

// [apc_host_model.sv]
// Host model: reads one word off the bus at each strobe rise.
// Assumes the block's outputs are registered on core_clk.
`timescale 1ns/1ps
`include "apc_consts.svh"
`default_nettype none
module apc_host_model (
   input  wire logic                   core_clk,
   input  wire logic                   rst_n,
   input  wire logic                   cs_req,
   input  wire logic                   rd_req,
   input  wire logic [`APC_DATA_W-1:0] dout_o,
   input  wire logic                   dout_oe,
   input  wire logic                   data_ready_strobe,
   input  wire logic                   out_of_range_flag,
   output var  logic                   chip_select_n,
   output var  logic                   read_enable_n,
   output var  apc_pkg::apc_word_t     word_q,
   output var  logic                   word_new
);
   logic [`APC_DATA_W-1:0] bus;
   logic [`APC_DATA_W-1:0] last_q;
   logic                   stb_q;
   // Floating bus flips every cycle so a stale word never passes
   assign bus = dout_oe ? dout_o : ~last_q;
   assign chip_select_n = ~cs_req;
   assign read_enable_n = ~rd_req;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         last_q <= 16'h0;
         stb_q <= 1'b0;
         word_q <= '0;
         word_new <= 1'b0;
      end else begin
         last_q <= bus;
         stb_q <= data_ready_strobe;
         word_new <= data_ready_strobe & ~stb_q;
         if (data_ready_strobe & ~stb_q) begin
            word_q <= {out_of_range_flag, bus};
         end
      end
   end
endmodule
`default_nettype wire

// [apc_output_ctrl.sv]
// Readout control: rate select, sync, data-ready strobe, output bus gating.
// Assumes modulator samples arrive on core_clk; pins are asynchronous.
`timescale 1ns/1ps
`include "apc_consts.svh"
`default_nettype none
module apc_output_ctrl #(
   parameter int STROBE_HALF   = `APC_STROBE_HALF,
   parameter int SETTLE_CYCLES = `APC_SETTLE_CYCLES
) (
   input  wire logic                   core_clk,
   input  wire logic                   rst_n,
   input  wire logic                   double_rate_select,
   input  wire logic                   power_down_n,
   input  wire logic                   sync_n,
   input  wire logic                   chip_select_n,
   input  wire logic                   read_enable_n,
   input  wire logic                   mod_valid,
   input  wire logic [`APC_DATA_W-1:0] mod_data,
   input  wire logic                   mod_over_range,
   output var  logic                   mod_ready,
   output var  logic [`APC_DATA_W-1:0] dout_o,
   output var  logic                   dout_oe,
   output var  logic                   data_ready_strobe,
   output var  logic                   out_of_range_flag,
   output var  logic                   result_valid
);
   localparam int SCW = $clog2(2 * STROBE_HALF);
   localparam logic [SCW-1:0] STB_TOP = SCW'(2 * STROBE_HALF - 1);
   localparam logic [SCW-1:0] STB_FALL = SCW'(STROBE_HALF - 1);
   localparam logic [5:0] SETTLE_TOP = 6'(SETTLE_CYCLES);

   // Pin synchronisers
   logic [4:0] pin_meta_q;
   logic [4:0] pin_sync_q;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_q <= `APC_PIN_RST;
         pin_sync_q <= `APC_PIN_RST;
      end else begin
         pin_meta_q <= {double_rate_select, power_down_n, sync_n,
                        chip_select_n, read_enable_n};
         pin_sync_q <= pin_meta_q;
      end
   end
   logic dbl_s;
   logic pd_n_s;
   logic sync_n_s;
   logic cs_n_s;
   logic rd_n_s;
   assign dbl_s    = pin_sync_q[`APC_PIN_DBL];
   assign pd_n_s   = pin_sync_q[`APC_PIN_PD_N];
   assign sync_n_s = pin_sync_q[`APC_PIN_SYNC_N];
   assign cs_n_s   = pin_sync_q[`APC_PIN_CS_N];
   assign rd_n_s   = pin_sync_q[`APC_PIN_RD_N];

   function automatic logic [2:0] ratio_of(input logic dbl);
      return dbl ? `APC_RATIO_DOUBLE : `APC_RATIO_NORM;
   endfunction

   // Control state, strobe and settling count
   apc_pkg::apc_state_t state_q;
   apc_pkg::apc_state_t state_d;
   logic [SCW-1:0]      stb_cnt_q;
   logic [SCW-1:0]      stb_cnt_d;
   logic                strobe_q;
   logic                strobe_d;
   logic [5:0]          settle_q;
   logic [5:0]          settle_d;
   logic                run_q;
   logic                run_d;
   logic                load;

   assign run_q = (state_q == apc_pkg::APC_ST_SETTLE) ||
                  (state_q == apc_pkg::APC_ST_READY);
   assign load  = run_q && (stb_cnt_q == STB_TOP);

   always_comb begin
      state_d   = state_q;
      stb_cnt_d = stb_cnt_q;
      strobe_d  = strobe_q;
      settle_d  = settle_q;
      if (run_q) begin
         stb_cnt_d = stb_cnt_q + SCW'(1);
         if (load) begin
            stb_cnt_d = '0;
            strobe_d  = 1'b1;
         end else if (stb_cnt_q == STB_FALL) begin
            strobe_d  = 1'b0;
         end
      end
      unique case (state_q)
         apc_pkg::APC_ST_DOWN:   state_d = apc_pkg::APC_ST_SYNC;
         apc_pkg::APC_ST_SYNC:   state_d = apc_pkg::APC_ST_SETTLE;
         apc_pkg::APC_ST_SETTLE: begin
            if (load) begin
               settle_d = settle_q + 6'h01;
            end
            if (settle_q == SETTLE_TOP) begin
               state_d = apc_pkg::APC_ST_READY;
            end
         end
         apc_pkg::APC_ST_READY:  state_d = apc_pkg::APC_ST_READY;
      endcase
      // Power-down outranks sync; both restart filter settling
      if (!pd_n_s || !sync_n_s) begin
         state_d   = pd_n_s ? apc_pkg::APC_ST_SYNC
                            : apc_pkg::APC_ST_DOWN;
         stb_cnt_d = '0;
         strobe_d  = 1'b0;
         settle_d  = '0;
      end
   end
   assign run_d = (state_d == apc_pkg::APC_ST_SETTLE) ||
                  (state_d == apc_pkg::APC_ST_READY);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q   <= apc_pkg::APC_ST_SYNC;
         stb_cnt_q <= '0;
         strobe_q  <= 1'b0;
         settle_q  <= '0;
         result_valid <= 1'b0;
      end else begin
         state_q   <= state_d;
         stb_cnt_q <= stb_cnt_d;
         strobe_q  <= strobe_d;
         settle_q  <= settle_d;
         result_valid <= (state_d == apc_pkg::APC_ST_READY);
      end
   end

   // Decimator and two-entry word buffer
   apc_pkg::apc_word_t buf_mem_q [2];
   apc_pkg::apc_word_t buf_mem_d [2];
   logic [1:0]         buf_cnt_q;
   logic [1:0]         buf_cnt_d;
   logic               wp_q;
   logic               wp_d;
   logic               rp_q;
   logic               rp_d;
   logic [2:0]         dec_cnt_q;
   logic [2:0]         dec_cnt_d;
   logic               ovr_acc_q;
   logic               ovr_acc_d;
   logic               ready_q;
   logic               ready_d;
   logic               fire;
   logic               push;
   logic               pop;

   // Ready is registered but exact: it is computed from the next fill count
   assign fire = mod_valid && ready_q;
   assign push = fire && (dec_cnt_q >= ratio_of(dbl_s) - 3'h1);
   assign pop  = load && (buf_cnt_q != 2'h0);

   always_comb begin
      buf_mem_d = buf_mem_q;
      buf_cnt_d = buf_cnt_q;
      wp_d      = wp_q;
      rp_d      = rp_q;
      dec_cnt_d = dec_cnt_q;
      ovr_acc_d = ovr_acc_q;
      if (fire) begin
         if (push) begin
            buf_mem_d[wp_q] = '{ovr: ovr_acc_q || mod_over_range,
                                data: mod_data};
            wp_d      = ~wp_q;
            dec_cnt_d = 3'h0;
            ovr_acc_d = 1'b0;
         end else begin
            dec_cnt_d = dec_cnt_q + 3'h1;
            ovr_acc_d = ovr_acc_q || mod_over_range;
         end
      end
      if (pop) begin
         rp_d = ~rp_q;
      end
      buf_cnt_d = buf_cnt_q + {1'b0, push} - {1'b0, pop};
      if (!run_d) begin
         // Stale samples must not leak past a sync or power-down
         buf_cnt_d = 2'h0;
         wp_d      = 1'b0;
         rp_d      = 1'b0;
         dec_cnt_d = 3'h0;
         ovr_acc_d = 1'b0;
      end
      ready_d = run_d && (buf_cnt_d != 2'h2);
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         buf_mem_q[0] <= '0;
         buf_mem_q[1] <= '0;
         buf_cnt_q    <= 2'h0;
         wp_q         <= 1'b0;
         rp_q         <= 1'b0;
         dec_cnt_q    <= 3'h0;
         ovr_acc_q    <= 1'b0;
         ready_q      <= 1'b0;
      end else begin
         buf_mem_q <= buf_mem_d;
         buf_cnt_q <= buf_cnt_d;
         wp_q      <= wp_d;
         rp_q      <= rp_d;
         dec_cnt_q <= dec_cnt_d;
         ovr_acc_q <= ovr_acc_d;
         ready_q   <= ready_d;
      end
   end

   // Output word, range flag and bus enable
   logic [`APC_DATA_W-1:0] word_q;
   logic [`APC_DATA_W-1:0] word_d;
   logic                   ovr_q;
   logic                   ovr_d;
   logic                   oe_q;
   logic                   oe_d;

   always_comb begin
      word_d = word_q;
      ovr_d  = ovr_q;
      if (pop) begin
         word_d = buf_mem_q[rp_q].data;
         ovr_d  = buf_mem_q[rp_q].ovr;
      end
      if (!sync_n_s) begin
         word_d = '0;
         ovr_d  = 1'b0;
      end
      oe_d = !cs_n_s && !rd_n_s;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         word_q <= '0;
         ovr_q  <= 1'b0;
         oe_q   <= 1'b0;
      end else begin
         word_q <= word_d;
         ovr_q  <= ovr_d;
         oe_q   <= oe_d;
      end
   end

   assign mod_ready         = ready_q;
   assign dout_o            = word_q;
   assign dout_oe           = oe_q;
   assign data_ready_strobe = strobe_q;
   assign out_of_range_flag = ovr_q;

   // Checks
   property p_bus_float;
      @(posedge core_clk) disable iff (!rst_n)
      (cs_n_s || rd_n_s) |=> !dout_oe;
   endproperty
   a_bus_float: assert property (p_bus_float)
      else $error("bus still driven after deselect");

   property p_bus_drive;
      @(posedge core_clk) disable iff (!rst_n)
      (!cs_n_s && !rd_n_s) |=> dout_oe;
   endproperty
   a_bus_drive: assert property (p_bus_drive)
      else $error("bus not driven after select");

   property p_sync_zero;
      @(posedge core_clk) disable iff (!rst_n)
      !sync_n_s |=> (dout_o == '0) && !out_of_range_flag;
   endproperty
   a_sync_zero: assert property (p_sync_zero)
      else $error("output not zero during sync");

   property p_strobe_high;
      @(posedge core_clk) disable iff (!rst_n || !run_q)
      $rose(data_ready_strobe) |-> data_ready_strobe[*4] ##1
         !data_ready_strobe;
   endproperty
   a_strobe_high: assert property (p_strobe_high)
      else $error("strobe high phase wrong length");

   property p_strobe_low;
      @(posedge core_clk) disable iff (!rst_n || !run_q)
      $fell(data_ready_strobe) |-> !data_ready_strobe[*4] ##1
         data_ready_strobe;
   endproperty
   a_strobe_low: assert property (p_strobe_low)
      else $error("strobe low phase wrong length");

   property p_halt;
      @(posedge core_clk) disable iff (!rst_n)
      !pd_n_s |=> !mod_ready && !data_ready_strobe;
   endproperty
   a_halt: assert property (p_halt)
      else $error("activity during power-down");

   property p_settle;
      @(posedge core_clk) disable iff (!rst_n)
      $rose(result_valid) |-> $past(settle_q) == SETTLE_TOP;
   endproperty
   a_settle: assert property (p_settle)
      else $error("settling ended at wrong strobe count");

   property p_word_at_strobe;
      @(posedge core_clk) disable iff (!rst_n)
      (sync_n_s && !$stable(dout_o)) |-> $rose(data_ready_strobe);
   endproperty
   a_word_at_strobe: assert property (p_word_at_strobe)
      else $error("word changed away from strobe rise");

   property p_decimate;
      @(posedge core_clk) disable iff (!rst_n)
      (push && !dbl_s) |-> dec_cnt_q == 3'h5;
   endproperty
   a_decimate: assert property (p_decimate)
      else $error("normal mode word not after six samples");

   property p_decimate_dbl;
      @(posedge core_clk) disable iff (!rst_n)
      (fire && dbl_s && dec_cnt_q == 3'h2) |-> push;
   endproperty
   a_decimate_dbl: assert property (p_decimate_dbl)
      else $error("double mode word not after three samples");
endmodule
`default_nettype wire

// [apc_output_ctrl_tb.sv]
// Testbench of the readout control block with a host model.
// Assumes a short settling count to keep the run brief.
`timescale 1ns/1ps
`include "apc_consts.svh"
`default_nettype none
module apc_output_ctrl_tb;
   logic                   core_clk = 1'b0;
   logic                   rst_n = 1'b0;
   logic                   double_rate_select = 1'b0;
   logic                   power_down_n = 1'b1;
   logic                   sync_n = 1'b1;
   logic                   cs_req = 1'b0;
   logic                   rd_req = 1'b0;
   logic                   mod_valid = 1'b0;
   logic [`APC_DATA_W-1:0] mod_data = 16'h1;
   logic [`APC_DATA_W-1:0] ovr_at = 16'h0;
   wire logic              mod_over_range = (mod_data == ovr_at);
   logic                   mod_ready;
   logic                   dout_oe;
   logic                   data_ready_strobe;
   logic                   out_of_range_flag;
   logic                   result_valid;
   logic                   chip_select_n;
   logic                   read_enable_n;
   logic                   word_new;
   logic [`APC_DATA_W-1:0] dout_o;
   apc_pkg::apc_word_t     word_q;
   int                     mismatches = 0;
   int                     comparisons = 0;
   always #2 core_clk = ~core_clk;
   // Sample value counts samples taken since sync, so word data tells ratio
   always @(posedge core_clk) begin
      if (!sync_n) mod_data <= 16'h1;
      else if (mod_valid && mod_ready) mod_data <= mod_data + 16'h1;
   end
   apc_output_ctrl #(.SETTLE_CYCLES(3)) u_apc_output_ctrl (
      .core_clk(core_clk), .rst_n(rst_n),
      .double_rate_select(double_rate_select),
      .power_down_n(power_down_n), .sync_n(sync_n),
      .chip_select_n(chip_select_n), .read_enable_n(read_enable_n),
      .mod_valid(mod_valid), .mod_data(mod_data),
      .mod_over_range(mod_over_range), .mod_ready(mod_ready),
      .dout_o(dout_o), .dout_oe(dout_oe),
      .data_ready_strobe(data_ready_strobe),
      .out_of_range_flag(out_of_range_flag), .result_valid(result_valid));
   apc_host_model u_apc_host_model (
      .core_clk(core_clk), .rst_n(rst_n), .cs_req(cs_req),
      .rd_req(rd_req), .dout_o(dout_o), .dout_oe(dout_oe),
      .data_ready_strobe(data_ready_strobe),
      .out_of_range_flag(out_of_range_flag),
      .chip_select_n(chip_select_n), .read_enable_n(read_enable_n),
      .word_q(word_q), .word_new(word_new));
   task automatic chk(input string what, input logic [16:0] e, g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic run_len(input logic v, output int h);
      h = 0;
      while (data_ready_strobe === v && h < 40) begin
         tick(1);
         h++;
      end
   endtask
   task automatic get_word(output apc_pkg::apc_word_t w);
      int n;
      n = 0;
      do begin
         tick(1);
         n++;
      end while (word_new !== 1'b1 && n < 60);
      chk("word seen", 17'h1, 17'(word_new));
      w = word_q;
   endtask
   task automatic t_bus(input logic cs, input logic rd);
      @(posedge core_clk) {cs_req, rd_req} <= 2'h3;
      tick(2);
      chk("oe early", 17'h0, 17'(dout_oe));
      tick(1);
      chk("oe on", 17'h1, 17'(dout_oe));
      @(posedge core_clk) {cs_req, rd_req} <= {cs, rd};
      tick(2);
      chk("oe held", 17'h1, 17'(dout_oe));
      tick(1);
      chk("oe off", 17'h0, 17'(dout_oe));
      $display("test bus %b%b done", cs, rd);
   endtask
   task automatic t_stream(input logic dbl, input int r);
      apc_pkg::apc_word_t w;
      @(posedge core_clk) begin
         sync_n <= 1'b0;
         double_rate_select <= dbl;
         ovr_at <= 16'(r + 2);
         {cs_req, rd_req} <= 2'h3;
      end
      tick(3);
      chk("dout in sync", 17'h0, 17'(dout_o));
      @(posedge core_clk);
      tick(6);
      chk("dout held", 17'h0, 17'(dout_o));
      @(posedge core_clk) sync_n <= 1'b1;
      for (int k = 1; k <= 5; k++) begin
         get_word(w);
         chk("word data", 17'(r*k), 17'(w.data));
         chk("word ovr", 17'(k == 2), 17'(w.ovr));
         if (k == 1) chk("settling", 17'h0, 17'(result_valid));
      end
      chk("settled", 17'h1, 17'(result_valid));
      $display("test stream ratio %0d done", r);
   endtask
   task automatic t_strobe();
      int h;
      run_len(1'b1, h);
      run_len(1'b0, h);
      run_len(1'b1, h);
      chk("strobe high", 17'(`APC_STROBE_HALF), 17'(h));
      run_len(1'b0, h);
      chk("strobe low", 17'(`APC_STROBE_HALF), 17'(h));
      $display("test strobe done");
   endtask
   task automatic t_pd();
      apc_pkg::apc_word_t w;
      int h;
      @(posedge core_clk) power_down_n <= 1'b0;
      tick(4);
      run_len(1'b0, h);
      chk("strobe halted", 17'h1, 17'(h >= 40));
      chk("ready halted", 17'h0, 17'(mod_ready));
      @(posedge core_clk) power_down_n <= 1'b1;
      get_word(w);
      chk("resettling", 17'h0, 17'(result_valid));
      $display("test power down done");
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      tick(2);
      chk("oe in reset", 17'h0, 17'(dout_oe));
      chk("dout in reset", 17'h0, 17'(dout_o));
      @(posedge core_clk) begin
         rst_n <= 1'b1;
         mod_valid <= 1'b1;
      end
      t_bus(1'b0, 1'b1);
      t_bus(1'b1, 1'b0);
      t_stream(1'b0, 6);
      t_strobe();
      t_stream(1'b1, 3);
      t_pd();
      finish_test();
   end
   // About 200 cycles are needed; the limit allows over twenty times that
   initial begin
      #20000;
      mismatches++;
      finish_test();
   end
endmodule
`default_nettype wire

// [apc_pkg.sv]
// Types of the parallel output control block.
// Assumes apc_consts.svh is on the include path.
`include "apc_consts.svh"
package apc_pkg;
   typedef struct packed {
      logic                    ovr;
      logic [`APC_DATA_W-1:0]  data;
   } apc_word_t;

   typedef enum logic [1:0] {
      APC_ST_DOWN   = 2'h2,
      APC_ST_SYNC   = 2'h0,
      APC_ST_SETTLE = 2'h1,
      APC_ST_READY  = 2'h3
   } apc_state_t;
endpackage
